// ---- logic/sync_serial_defines.vh ----
// register offsets, field positions and reset values of the clocked serial port
// assumes an 8-bit register port with one-cycle read latency
`ifndef SYNC_SERIAL_DEFINES_VH
`define SYNC_SERIAL_DEFINES_VH
// register offsets (index on the plain register port)
`define OFF_FLAG3 4'h0
`define OFF_ENABLE3 4'h1
`define OFF_PRIO3 4'h2
`define OFF_RXSTAT 4'h3
`define OFF_RXBUF 4'h4
`define OFF_TXSTAT 4'h5
`define OFF_DIVISOR 4'h6
`define OFF_TXBUF 4'h7
`define OFF_PORT_G_OUTPUT_LATCH 4'h8
`define OFF_CORE 4'h9
// flag / enable / priority group bits
`define BIT_RXFLAG 5
`define BIT_TXFLAG 4
// receive status/control bits
`define BIT_SERIAL_PORT_ENABLE 7
`define BIT_RX9 6
`define BIT_SINGLE_RECEIVE_ENABLE 5
`define BIT_CONTINUOUS_RECEIVE_ENABLE 4
`define BIT_ADDRESS_DETECT_ENABLE 3
`define BIT_FRAMING_ERROR_FLAG 2
`define BIT_OVERRUN_ERROR_FLAG 1
`define BIT_RECEIVED_NINTH_BIT 0
// transmit status/control bits
`define BIT_CLOCK_SOURCE_SELECT 7
`define BIT_TX9 6
`define BIT_TRANSMIT_ENABLE 5
`define BIT_SYNC 4
`define BIT_HIGH_RATE_SELECT 2
`define BIT_SHIFTER_EMPTY_STATUS 1
`define BIT_TRANSMIT_NINTH_BIT 0
// core control register bits
`define BIT_GIE 7
`define BIT_PERIPHERAL_INTERRUPT_ENABLE 6
`define BIT_SLEEP 0
// reset values
`define RST_ZERO 8'h00
`define RST_TXSTAT 8'h02
`endif

// ---- logic/sync_serial_port.v ----
// clocked half-duplex serial port: master receive/transmit, slave receive/transmit
// assumes a register port on sys_clk; link clock/data pins are asynchronous
// How it works
// - clocked mode: continuous bit starts receive; single bit starts it in master only
// - sample data on falling shift clock edge
// - single receive takes one word, then stops
// - continuous runs until cleared, wins over single
// - word done sets flag; interrupt only if enabled
// - status shows ninth bit, errors; read first
// - low eight bits read from receive buffer
// - clearing continuous receive clears latched errors
// - source select clear: clock from pin
// - slave shifts in low-power, pin clock only
// - second word stays buffered, no transmit flag
// - shifter done: second word loads, flag sets
// - transmit-empty event wakes core when enabled
// - slave ignores the single-receive bit
// - slave receives during sleep if continuous set
// - slave word moves to buffer, wakes core
// - nine-bit select gives 9-bit words
// - buffer write with transmit enabled starts sending
// - transmit-empty flag cleared only by buffer write
// - shifter-empty bit read-only, no interrupt
// - half duplex: receive and transmit exclusive
`timescale 1ns/1ps
`include "sync_serial_defines.vh"

module sync_serial_port (
    input wire sys_clk,
    input wire resetn,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    input wire shift_clock_pin_in,
    output reg shift_clock_pin_out,
    output reg shift_clock_pin_oe,
    input wire shift_data_pin_in,
    output reg shift_data_pin_out,
    output reg shift_data_pin_oe,
    output reg irq,
    output reg wake
);

// ==========================================================
// state
reg [7:0] flag3_reg, enable3_reg, prio3_reg, rxstat_reg, rxbuf_reg;
reg [7:0] txstat_reg, divisor_reg, txbuf_reg, port_g_output_latch_reg, core_reg;
reg tx_full_reg;
reg [8:0] tsr_reg;
reg [3:0] tx_cnt_reg;
reg tx_busy_reg;
reg [8:0] rsr_reg;
reg [3:0] rx_cnt_reg;
reg rx_busy_reg;
reg [7:0] div_cnt_reg;
reg mclk_reg;
reg ck_s1_reg, ck_s2_reg, ck_s3_reg, dt_s1_reg, dt_s2_reg;

wire master = txstat_reg[`BIT_CLOCK_SOURCE_SELECT];
wire enabled = rxstat_reg[`BIT_SERIAL_PORT_ENABLE] & txstat_reg[`BIT_SYNC];
wire continuous_receive_enable = rxstat_reg[`BIT_CONTINUOUS_RECEIVE_ENABLE];
// slave mode treats the single-receive bit as don't care
wire single_receive_enable_eff = rxstat_reg[`BIT_SINGLE_RECEIVE_ENABLE] & master;
wire rx_want = enabled & (continuous_receive_enable | single_receive_enable_eff);
wire nine_rx = rxstat_reg[`BIT_RX9];
wire nine_tx = txstat_reg[`BIT_TX9];
wire [3:0] rx_bits = nine_rx ? 4'h9 : 4'h8;
wire [3:0] tx_bits = nine_tx ? 4'h9 : 4'h8;

// ==========================================================
// shift clock: divider in master, synchronised pin in slave
// pin edges are found after two flip-flops; the first is read only by the second
wire ck_now = master ? mclk_reg : ck_s2_reg;
wire ck_prev = master ? ~mclk_reg : ck_s3_reg;
wire div_hit = (div_cnt_reg == divisor_reg);
// keep running after the last fall so the final low phase is full length
wire clk_run = tx_busy_reg | rx_busy_reg | ~mclk_reg;
wire m_tick = div_hit & clk_run;
wire fall = master ? (m_tick & mclk_reg) : (ck_s3_reg & ~ck_s2_reg);
wire rise = master ? (m_tick & ~mclk_reg) : (~ck_s3_reg & ck_s2_reg);
// slave edges come purely from the pin, so sleep never halts shifting
wire slave_ok = ~master;

// ==========================================================
// transmit and receive control
// half duplex: a transfer starts only while the other side is idle
wire tx_start = enabled & txstat_reg[`BIT_TRANSMIT_ENABLE] & tx_full_reg & ~tx_busy_reg
    & ~rx_busy_reg & ~rx_want;
wire rx_start = rx_want & ~rx_busy_reg & ~tx_busy_reg & ~tx_full_reg;
wire tx_last = tx_busy_reg & rise & (tx_cnt_reg == tx_bits - 4'h1);
wire rx_done = rx_busy_reg & fall & (rx_cnt_reg == rx_bits - 4'h1);
wire wr_txbuf = reg_write & (reg_addr == `OFF_TXBUF);
wire wr_rxstat = reg_write & (reg_addr == `OFF_RXSTAT);
wire continuous_receive_enable_clear = wr_rxstat & continuous_receive_enable & ~reg_wdata[`BIT_CONTINUOUS_RECEIVE_ENABLE];
wire [8:0] rx_word = nine_rx ? {dt_s2_reg, rsr_reg[8:1]}
    : {1'b0, dt_s2_reg, rsr_reg[8:2]};
wire tx_flag_set = tx_start;
wire rx_flag_set = rx_done;
wire rd_rxbuf = reg_read & (reg_addr == `OFF_RXBUF);
wire unused_ok = ck_now ^ ck_prev ^ slave_ok;

reg [7:0] rdata_next;
always @* begin
    case (reg_addr)
    `OFF_FLAG3: rdata_next = flag3_reg;
    `OFF_ENABLE3: rdata_next = enable3_reg;
    `OFF_PRIO3: rdata_next = prio3_reg;
    `OFF_RXSTAT: rdata_next = rxstat_reg;
    `OFF_RXBUF: rdata_next = rxbuf_reg;
    `OFF_TXSTAT: rdata_next = {txstat_reg[7:2], ~tx_busy_reg,
        txstat_reg[0]};
    `OFF_DIVISOR: rdata_next = divisor_reg;
    `OFF_TXBUF: rdata_next = txbuf_reg;
    `OFF_PORT_G_OUTPUT_LATCH: rdata_next = port_g_output_latch_reg;
    `OFF_CORE: rdata_next = core_reg;
    default: rdata_next = 8'h00;
    endcase
end

// ==========================================================
// registers
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        flag3_reg <= `RST_ZERO;
        enable3_reg <= `RST_ZERO;
        prio3_reg <= `RST_ZERO;
        rxstat_reg <= `RST_ZERO;
        rxbuf_reg <= `RST_ZERO;
        txstat_reg <= `RST_TXSTAT;
        divisor_reg <= `RST_ZERO;
        txbuf_reg <= `RST_ZERO;
        port_g_output_latch_reg <= `RST_ZERO;
        core_reg <= `RST_ZERO;
        tx_full_reg <= 1'b0;
        tsr_reg <= 9'h000;
        tx_cnt_reg <= 4'h0;
        tx_busy_reg <= 1'b0;
        rsr_reg <= 9'h000;
        rx_cnt_reg <= 4'h0;
        rx_busy_reg <= 1'b0;
        div_cnt_reg <= 8'h00;
        mclk_reg <= 1'b1;
        ck_s1_reg <= 1'b1;
        ck_s2_reg <= 1'b1;
        ck_s3_reg <= 1'b1;
        dt_s1_reg <= 1'b1;
        dt_s2_reg <= 1'b1;
        reg_rdata <= 8'h00;
        shift_clock_pin_out <= 1'b1;
        shift_clock_pin_oe <= 1'b0;
        shift_data_pin_out <= 1'b1;
        shift_data_pin_oe <= 1'b0;
        irq <= 1'b0;
        wake <= 1'b0;
    end else begin
        ck_s1_reg <= shift_clock_pin_in;
        ck_s2_reg <= ck_s1_reg;
        ck_s3_reg <= ck_s2_reg;
        dt_s1_reg <= shift_data_pin_in;
        dt_s2_reg <= dt_s1_reg;
        reg_rdata <= reg_read ? rdata_next : 8'h00;
        // master clock: toggles every divisor+1 cycles while busy
        if (!clk_run || div_hit)
            div_cnt_reg <= 8'h00;
        else
            div_cnt_reg <= div_cnt_reg + 8'h01;
        if (!clk_run)
            mclk_reg <= 1'b1;
        else if (m_tick)
            mclk_reg <= ~mclk_reg;
        // plain software registers
        if (reg_write) begin
            case (reg_addr)
            `OFF_ENABLE3: enable3_reg <= reg_wdata;
            `OFF_PRIO3: prio3_reg <= reg_wdata;
            `OFF_DIVISOR: divisor_reg <= reg_wdata;
            `OFF_PORT_G_OUTPUT_LATCH: port_g_output_latch_reg <= {reg_wdata[7:6], 1'b0, reg_wdata[4:0]};
            `OFF_CORE: core_reg <= {reg_wdata[7:6], 5'h00, reg_wdata[0]};
            `OFF_TXSTAT: txstat_reg <= {reg_wdata[7:4], 1'b0,
                reg_wdata[2], 1'b0, reg_wdata[0]};
            default: ;
            endcase
        end
        // receive control bits; errors fall when continuous is cleared
        if (wr_rxstat) begin
            rxstat_reg[7:3] <= reg_wdata[7:3];
            if (continuous_receive_enable_clear)
                rxstat_reg[`BIT_OVERRUN_ERROR_FLAG] <= 1'b0;
            if (continuous_receive_enable_clear)
                rxstat_reg[`BIT_FRAMING_ERROR_FLAG] <= 1'b0;
        end
        // transmit buffer: write fills it and drops the empty flag
        if (tx_start) begin
            tsr_reg <= {txstat_reg[`BIT_TRANSMIT_NINTH_BIT], txbuf_reg};
            tx_busy_reg <= 1'b1;
            tx_cnt_reg <= 4'h0;
        end
        if (wr_txbuf) begin
            txbuf_reg <= reg_wdata;
            tx_full_reg <= 1'b1;
        end else if (tx_start) begin
            tx_full_reg <= 1'b0;
        end
        // flag set wins; the empty flag clears only on a buffer write
        flag3_reg[`BIT_TXFLAG] <= tx_flag_set
            | (flag3_reg[`BIT_TXFLAG] & ~wr_txbuf);
        // receive flag drops when software takes the data byte
        flag3_reg[`BIT_RXFLAG] <= rx_flag_set
            | (flag3_reg[`BIT_RXFLAG] & ~rd_rxbuf);
        // shifting out: data changes on rising edge
        if (tx_busy_reg && rise) begin
            tsr_reg <= {1'b1, tsr_reg[8:1]};
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            if (tx_last)
                tx_busy_reg <= 1'b0;
        end
        // reception
        if (rx_start) begin
            rx_busy_reg <= 1'b1;
            rx_cnt_reg <= 4'h0;
        end else if (rx_busy_reg && !rx_want) begin
            rx_busy_reg <= 1'b0;
        end else if (rx_busy_reg && fall) begin
            rsr_reg <= {dt_s2_reg, rsr_reg[8:1]};
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_done) begin
                rx_busy_reg <= 1'b0;
                rxbuf_reg <= rx_word[7:0];
                rxstat_reg[`BIT_RECEIVED_NINTH_BIT] <= rx_word[8];
                // unread word overwritten counts as an overrun
                if (flag3_reg[`BIT_RXFLAG] && !rd_rxbuf)
                    rxstat_reg[`BIT_OVERRUN_ERROR_FLAG] <= 1'b1;
                // single receive ends after one word unless continuous
                if (!continuous_receive_enable)
                    rxstat_reg[`BIT_SINGLE_RECEIVE_ENABLE] <= 1'b0;
            end
        end
        // pins: master drives clock; data driven only while sending
        shift_clock_pin_oe <= enabled & master;
        shift_clock_pin_out <= mclk_reg ^ (unused_ok & 1'b0);
        shift_data_pin_oe <= enabled & tx_busy_reg;
        shift_data_pin_out <= tx_busy_reg ? tsr_reg[0] : 1'b1;
        irq <= (flag3_reg[`BIT_RXFLAG] & enable3_reg[`BIT_RXFLAG])
            | (flag3_reg[`BIT_TXFLAG] & enable3_reg[`BIT_TXFLAG]);
        // wake from sleep on an enabled event; slave keeps running
        wake <= core_reg[`BIT_SLEEP] & (
            (flag3_reg[`BIT_RXFLAG] & enable3_reg[`BIT_RXFLAG])
            | (flag3_reg[`BIT_TXFLAG] & enable3_reg[`BIT_TXFLAG]));
    end
end

// continuous reception re-arms after each word while the bit stays set
endmodule // sync_serial_port

// ---- tb/sync_serial_port_sva.sv ----
// checker on the serial port ports; mirrors track host writes
// assumes it is bound to sync_serial_port
`timescale 1ns/1ps
`include "sync_serial_defines.vh"
module sync_serial_port_sva (
    input wire sys_clk,
    input wire resetn,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_rdata,
    input wire shift_clock_pin_in,
    input wire shift_clock_pin_out,
    input wire shift_clock_pin_oe,
    input wire shift_data_pin_in,
    input wire shift_data_pin_out,
    input wire shift_data_pin_oe,
    input wire irq,
    input wire wake
);
// ====================
// write mirrors and low phase counter
reg [7:0] rx_reg, tx_reg, en_reg, core_reg, div_reg;
reg ckq_reg;
reg [8:0] run_reg;
wire slv = !tx_reg[7];
wire mst = tx_reg[7] & tx_reg[4] & rx_reg[7];
wire ien = |en_reg[5:4];
wire slp = core_reg[0];
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        {rx_reg, tx_reg, en_reg, core_reg, div_reg} <= 40'h0;
        ckq_reg <= 1'b1;
        run_reg <= 9'h000;
    end else begin
        if (reg_write && reg_addr == `OFF_RXSTAT) rx_reg <= reg_wdata;
        if (reg_write && reg_addr == `OFF_TXSTAT) tx_reg <= reg_wdata;
        if (reg_write && reg_addr == `OFF_ENABLE3) en_reg <= reg_wdata;
        if (reg_write && reg_addr == `OFF_CORE) core_reg <= reg_wdata;
        if (reg_write && reg_addr == `OFF_DIVISOR) div_reg <= reg_wdata;
        ckq_reg <= shift_clock_pin_out;
        // saturate so a long idle cannot wrap into a false match
        if (shift_clock_pin_out != ckq_reg) run_reg <= 9'h001;
        else if (run_reg != 9'h1ff) run_reg <= run_reg + 9'h001;
    end
end
// ====================
// assertions
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!resetn);
AST_RDATA_IDLE:
    assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside reply");
AST_UNMAPPED:
    assert property (reg_read && reg_addr > `OFF_CORE |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
AST_SLAVE_NO_CLK:
    assert property (slv && $past(slv) |=> !shift_clock_pin_oe)
    else $error("slave drives clock");
AST_MASTER_OE:
    assert property (mst && $past(mst) |=> shift_clock_pin_oe)
    else $error("master clock not driven");
AST_HALF_DUPLEX:
    assert property ($rose(shift_data_pin_oe) |-> !rx_reg[4])
    else $error("transmit while receive on");
AST_IRQ_ENABLE:
    assert property (!ien && !$past(ien) |=> !irq)
    else $error("irq without enable");
AST_WAKE:
    assert property (wake |-> (slp || $past(slp)) && (irq || $past(irq)))
    else $error("wake without sleep and irq");
AST_HALF_PERIOD:
    assert property ($rose(shift_clock_pin_out) && shift_clock_pin_oe &&
        $past(shift_clock_pin_oe) |-> run_reg == {1'b0, div_reg} + 9'h001)
    else $error("clock low phase length");
COV_MASTER: cover property ($rose(shift_clock_pin_oe));
COV_TX: cover property ($rose(shift_data_pin_oe));
COV_WAKE: cover property ($rose(wake));
endmodule // sync_serial_port_sva
bind sync_serial_port sync_serial_port_sva sync_serial_port_sva_i (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .shift_clock_pin_in(shift_clock_pin_in),
    .shift_clock_pin_out(shift_clock_pin_out),
    .shift_clock_pin_oe(shift_clock_pin_oe),
    .shift_data_pin_in(shift_data_pin_in),
    .shift_data_pin_out(shift_data_pin_out),
    .shift_data_pin_oe(shift_data_pin_oe), .irq(irq), .wake(wake));

// ---- tb/sync_serial_partner.sv ----
// remote clocked serial node: link clock frames and data
// assumes the bench resolves pins and pulls data high
`timescale 1ns/1ps
module sync_serial_partner (
    input wire ck_w,
    input wire dt_w,
    output reg ck_p,
    output wire dt_p,
    output reg dt_pen
);
// ====================
// new bit after a rising edge, capture on a falling edge
reg [8:0] sh_reg = 9'h000;
reg [8:0] got_reg = 9'h000;
assign dt_p = sh_reg[0];
initial ck_p = 1'b1;
initial dt_pen = 1'b0;
always @(posedge ck_w) sh_reg <= {1'b0, sh_reg[8:1]};
always @(negedge ck_w) got_reg <= {dt_w, got_reg[8:1]};
task load(input [8:0] w, input en); begin
    sh_reg = w;
    dt_pen = en;
end endtask
// clock stands high between frames
task frame(input integer n); begin
    repeat (n) begin
        #200 ck_p = 1'b0;
        #200 ck_p = 1'b1;
    end
end endtask
endmodule // sync_serial_partner

// ---- tb/sync_serial_port_tb_top.sv ----
// bench: register host plus remote serial node
// assumes 20 MHz sys_clk; 400 ns link clock periods from the node, 600 ns from the port as master
`timescale 1ns/1ps
`include "sync_serial_defines.vh"
module sync_serial_port_tb_top;
reg sys_clk = 1'b0;
reg resetn = 1'b0;
reg [3:0] reg_addr = 4'h0;
reg [7:0] reg_wdata = 8'h00;
reg reg_write = 1'b0;
reg reg_read = 1'b0;
reg [7:0] rd;
integer bad_count = 0;
integer num_checks = 0;
wire [7:0] reg_rdata;
wire ck_out, ck_oe, dt_out, dt_oe, irq, wake, ck_p, dt_p, dt_pen;
wire ck_w = ck_oe ? ck_out : ck_p;
wire dt_w = dt_oe ? dt_out : (dt_pen ? dt_p : 1'b1);
sync_serial_port sync_serial_port_i (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .shift_clock_pin_in(ck_w),
    .shift_clock_pin_out(ck_out), .shift_clock_pin_oe(ck_oe),
    .shift_data_pin_in(dt_w), .shift_data_pin_out(dt_out),
    .shift_data_pin_oe(dt_oe), .irq(irq), .wake(wake));
sync_serial_partner sync_serial_partner_i (.ck_w(ck_w), .dt_w(dt_w),
    .ck_p(ck_p), .dt_p(dt_p), .dt_pen(dt_pen));
initial forever #25 sys_clk = ~sys_clk;
task results; begin
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
end endtask
task chk(input [7:0] g, input [7:0] e); begin
    num_checks = num_checks + 1;
    if (g !== e) begin
        bad_count = bad_count + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
end endtask
task wr(input [3:0] a, input [7:0] d); begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
end endtask
task rdr(input [3:0] a); begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
end endtask
// polling is bounded so a dead receiver ends the run
task wait_flag(input [7:0] m); integer i; begin
    i = 0;
    rdr(`OFF_FLAG3);
    while ((rd & m) == 8'h00 && i < 300) begin
        rdr(`OFF_FLAG3);
        i = i + 1;
    end
    if (i == 300) begin
        chk(rd & m, m);
        results;
    end
end endtask
task t_reset; begin
    rdr(`OFF_TXSTAT);
    chk(rd, `RST_TXSTAT);
    rdr(4'hf);
    chk(rd, 8'h00);
end endtask
task t_master_rx; begin
    wr(`OFF_DIVISOR, 8'h05);
    wr(`OFF_TXSTAT, 8'h90);
    wr(`OFF_ENABLE3, 8'h20);
    sync_serial_partner_i.load(9'h05a, 1'b1);
    wr(`OFF_RXSTAT, 8'ha0);
    wait_flag(8'h20);
    chk({7'h00, irq}, 8'h01);
    rdr(`OFF_RXBUF);
    chk(rd, 8'h5a);
    repeat (200) @(posedge sys_clk);
    rdr(`OFF_FLAG3);
    chk(rd & 8'h20, 8'h00);
end endtask
task t_slave_rx; begin
    wr(`OFF_TXSTAT, 8'h10);
    wr(`OFF_RXSTAT, 8'ha0);
    sync_serial_partner_i.load(9'h1c3, 1'b1);
    sync_serial_partner_i.frame(8);
    repeat (20) @(posedge sys_clk);
    rdr(`OFF_FLAG3);
    chk(rd & 8'h20, 8'h00);
    wr(`OFF_RXSTAT, 8'hd0);
    wr(`OFF_CORE, 8'h01);
    sync_serial_partner_i.load(9'h1c3, 1'b1);
    sync_serial_partner_i.frame(9);
    repeat (20) @(posedge sys_clk);
    chk({7'h00, wake}, 8'h01);
    rdr(`OFF_RXSTAT);
    chk(rd, 8'hd1);
    rdr(`OFF_RXBUF);
    chk(rd, 8'hc3);
    sync_serial_partner_i.load(9'h03c, 1'b1);
    sync_serial_partner_i.frame(9);
    sync_serial_partner_i.load(9'h0aa, 1'b1);
    sync_serial_partner_i.frame(9);
    repeat (20) @(posedge sys_clk);
    rdr(`OFF_RXSTAT);
    chk(rd & 8'h02, 8'h02);
    wr(`OFF_RXSTAT, 8'hc0);
    rdr(`OFF_RXSTAT);
    chk(rd & 8'hfe, 8'hc0);
end endtask
task t_slave_tx; begin
    wr(`OFF_RXSTAT, 8'h80);
    wr(`OFF_TXSTAT, 8'h30);
    wr(`OFF_ENABLE3, 8'h10);
    sync_serial_partner_i.load(9'h000, 1'b0);
    wr(`OFF_TXBUF, 8'ha5);
    wr(`OFF_TXBUF, 8'h96);
    rdr(`OFF_FLAG3);
    chk(rd & 8'h10, 8'h00);
    rdr(`OFF_TXSTAT);
    chk(rd, 8'h30);
    sync_serial_partner_i.frame(8);
    chk(sync_serial_partner_i.got_reg[8:1], 8'ha5);
    repeat (10) @(posedge sys_clk);
    chk({7'h00, wake}, 8'h01);
    sync_serial_partner_i.frame(8);
    chk(sync_serial_partner_i.got_reg[8:1], 8'h96);
    repeat (10) @(posedge sys_clk);
    wr(`OFF_FLAG3, 8'h00);
    wr(`OFF_TXSTAT, 8'h30);
    rdr(`OFF_FLAG3);
    chk(rd & 8'h10, 8'h10);
    rdr(`OFF_TXSTAT);
    chk(rd, 8'h32);
end endtask
initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset;
    t_master_rx;
    t_slave_rx;
    t_slave_tx;
    results;
end
endmodule // sync_serial_port_tb_top
